/* File: tbc_evsys_model.sv */
// Prescaler and event routing model at the timer's far side
`timescale 1ns/10ps
module tbc_evsys_model (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [7:0] ev_req,
  input wire logic [7:0] ev_rise,
  input wire logic cascade_in,
  output logic [6:0] prescale_tick,
  output logic [7:0] event_in,
  output logic [7:0] event_edge_rise
);
  logic [6:0] div_reg;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_reg <= 7'h00;
    end else begin
      div_reg <= div_reg + 7'h01;
    end
  end
  // Tap n fires once every 2**n cycles
  always_comb begin
    for (int n = 0; n < 7; n++) begin
      prescale_tick[n] = (div_reg & ((7'h01 << n) - 7'h01)) == ((7'h01 << n) - 7'h01);
    end
  end
  // Overflow loops back on channel 7 as a cascade count input
  assign event_in = ev_req | {cascade_in, 7'h00};
  // Polarity line shows the inverse when idle, never a stale value
  assign event_edge_rise = ~(event_in ^ ev_rise);
endmodule

/* File: tbc_pkg.sv */
// Package of constants for the timer base counter with capture channels
package tbc_pkg;
  // Register offsets (word addresses on the plain register port)
  localparam logic [4:0] TBC_ADDR_CTRL = 5'h00;
  localparam logic [4:0] TBC_ADDR_STATUS = 5'h01;
  localparam logic [4:0] TBC_ADDR_COUNT = 5'h02;
  localparam logic [4:0] TBC_ADDR_PERIOD = 5'h03;
  localparam logic [4:0] TBC_ADDR_PER_SHADOW = 5'h04;
  localparam logic [4:0] TBC_ADDR_CH_BASE = 5'h08;
  localparam logic [4:0] TBC_ADDR_SH_BASE = 5'h0C;
  // Control field positions
  localparam int TBC_CTRL_CLKSRC_LSB = 0;
  localparam int TBC_CTRL_EVENT_ACTION_SELECT_LSB = 4;
  localparam int TBC_CTRL_EVSRC_LSB = 7;
  localparam int TBC_CTRL_DIR_BIT = 10;
  localparam int TBC_CTRL_WAVE_BIT = 11;
  localparam int TBC_CTRL_PERIOD_SHADOW_BIT = 12;
  localparam int TBC_CTRL_CHEN_LSB = 16;
  localparam logic [31:0] TBC_CTRL_RESET = 32'h0000_0000;
  localparam logic [15:0] TBC_PERIOD_RESET = 16'hFFFF;
  localparam logic [15:0] TBC_POLARITY_LIMIT = 16'h8000;
  // Clock source codes: 0 off, 1..7 prescaler taps, 8..15 event channel n-8
  localparam logic [3:0] TBC_CLK_OFF = 4'h0;
  localparam logic [3:0] TBC_CLK_EVENT_BASE = 4'h8;
  typedef enum logic [2:0] {
    TBC_EV_OFF = 3'b000,
    TBC_EV_CAPTURE = 3'b001,
    TBC_EV_UPDOWN = 3'b010,
    TBC_EV_QUAD = 3'b011
  } tbc_event_action_select_e;
endpackage

/* File: tbc_timer.sv */
// Timer base counter with double-buffered period and compare/capture channels
`timescale 1ns/10ps
module tbc_timer
  import tbc_pkg::*;
#(
  parameter int NUM_CH = 4,
  parameter int NUM_EV = 8,
  parameter int NUM_PRE = 7
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [NUM_PRE-1:0] prescale_tick,
  input wire logic [NUM_EV-1:0] event_in,
  input wire logic [NUM_EV-1:0] event_edge_rise,
  input wire logic quad_dir,
  output logic overflow_event,
  output logic [NUM_CH-1:0] match_event,
  output logic [NUM_CH-1:0] channel_flag,
  output logic [NUM_CH-1:0] capture_irq
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_reg;
  logic [15:0] count_value_reg;
  logic [15:0] period_reg;
  logic [15:0] period_shadow_reg;
  logic period_valid_reg;
  logic [15:0] channel_register_reg [NUM_CH];
  logic [15:0] channel_shadow_reg [NUM_CH];
  logic [NUM_CH-1:0] shadow_valid_flag_reg;
  logic [NUM_CH-1:0] channel_flag_reg;
  logic [NUM_CH-1:0] match_reg;
  logic [NUM_CH-1:0] cap_irq_reg;
  logic ovf_reg;
  logic [31:0] rdata_reg;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire [3:0] clock_source_select = ctrl_reg[TBC_CTRL_CLKSRC_LSB +: 4];
  wire [2:0] event_action_select = ctrl_reg[TBC_CTRL_EVENT_ACTION_SELECT_LSB +: 3];
  wire [2:0] event_source_select = ctrl_reg[TBC_CTRL_EVSRC_LSB +: 3];
  wire count_down = ctrl_reg[TBC_CTRL_DIR_BIT];
  wire wave_top_cha = ctrl_reg[TBC_CTRL_WAVE_BIT];
  wire per_buffered = ctrl_reg[TBC_CTRL_PERIOD_SHADOW_BIT];
  wire [NUM_CH-1:0] chan_enable = ctrl_reg[TBC_CTRL_CHEN_LSB +: NUM_CH];
  wire capture_mode = (event_action_select == TBC_EV_CAPTURE);
  wire updown_mode = (event_action_select == TBC_EV_UPDOWN);
  wire quad_mode = (event_action_select == TBC_EV_QUAD);

  wire wr_ctrl = reg_wr && (reg_addr == TBC_ADDR_CTRL);
  wire wr_count = reg_wr && (reg_addr == TBC_ADDR_COUNT);
  wire wr_period = reg_wr && (reg_addr == TBC_ADDR_PERIOD);
  wire wr_per_sh = reg_wr && (reg_addr == TBC_ADDR_PER_SHADOW);
  wire [1:0] ch_idx = reg_addr[1:0];
  wire wr_chan = reg_wr && (reg_addr[4:2] == TBC_ADDR_CH_BASE[4:2]);
  wire wr_shadow = reg_wr && (reg_addr[4:2] == TBC_ADDR_SH_BASE[4:2]);
  wire rd_chan = reg_rd && (reg_addr[4:2] == TBC_ADDR_CH_BASE[4:2]);

  // ----------------------------------------------------------------
  // Clock source and count tick
  // ----------------------------------------------------------------
  // Source off by default so a freshly reset timer never moves
  wire src_is_event = clock_source_select >= TBC_CLK_EVENT_BASE;
  wire [2:0] src_ev_idx = clock_source_select[2:0];
  wire [2:0] src_pre_idx = 3'(clock_source_select[2:0] - 3'h1);
  wire pre_tick = (clock_source_select != TBC_CLK_OFF) && !src_is_event
                  && (int'(src_pre_idx) < NUM_PRE) && prescale_tick[src_pre_idx];
  // The low timer's overflow_event routed to event_in gives the high half
  wire ev_tick = src_is_event && (int'(src_ev_idx) < NUM_EV) && event_in[src_ev_idx];
  wire count_tick = pre_tick || ev_tick;
  // Up/down mode relies on an event source being selected; quad mode takes direction from quad_dir
  wire dir_down = quad_mode ? quad_dir
                : updown_mode ? event_in[event_source_select] : count_down;

  // ----------------------------------------------------------------
  // Sequence points
  // ----------------------------------------------------------------
  wire [15:0] high_value = wave_top_cha ? channel_register_reg[0] : period_reg;
  wire at_zero = (count_value_reg == 16'h0000);
  wire at_high = (count_value_reg == high_value);
  wire load_point = count_tick && (wave_top_cha ? at_zero
                    : (dir_down ? at_zero : at_high));
  logic [15:0] count_next;
  always_comb begin
    count_next = count_value_reg;
    if (wr_count) begin
      count_next = reg_wdata[15:0];
    end else if (count_tick) begin
      if (dir_down) begin
        count_next = at_zero ? high_value : 16'(count_value_reg - 16'h0001);
      end else begin
        count_next = at_high ? 16'h0000 : 16'(count_value_reg + 16'h0001);
      end
    end
  end

  // ----------------------------------------------------------------
  // Counter and period
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= TBC_CTRL_RESET;
      count_value_reg <= 16'h0000;
      ovf_reg <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= reg_wdata;
      end
      count_value_reg <= count_next;
      ovf_reg <= count_tick && !wr_count && (dir_down ? at_zero : at_high);
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      period_reg <= TBC_PERIOD_RESET;
      period_shadow_reg <= 16'h0000;
      period_valid_reg <= 1'b0;
    end else begin
      if (wr_period) begin
        period_reg <= reg_wdata[15:0];
      end else if (per_buffered && load_point && period_valid_reg) begin
        period_reg <= period_shadow_reg;
      end
      if (wr_per_sh) begin
        period_shadow_reg <= reg_wdata[15:0];
      end
      // Write wins over a coincident load so a fresh value is not dropped
      if (wr_per_sh) begin
        period_valid_reg <= 1'b1;
      end else if (load_point) begin
        period_valid_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  wire polarity_ok = period_reg < TBC_POLARITY_LIMIT;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      localparam logic [1:0] IDX = 2'(gi);
      wire [2:0] ev_sel = 3'(event_source_select + 3'(gi));
      wire cap_ev = capture_mode && chan_enable[gi] && event_in[ev_sel];
      wire [15:0] stamp = polarity_ok
                        ? {event_edge_rise[ev_sel], count_value_reg[14:0]}
                        : count_value_reg;
      wire ch_wr = wr_chan && (ch_idx == IDX);
      wire sh_wr = wr_shadow && (ch_idx == IDX);
      wire ch_rd = rd_chan && (ch_idx == IDX);
      wire ch_empty = !channel_flag_reg[gi] || ch_rd;
      wire move = capture_mode && (shadow_valid_flag_reg[gi] || cap_ev) && ch_empty;
      wire [15:0] move_val = shadow_valid_flag_reg[gi] ? channel_shadow_reg[gi] : stamp;
      // Capture when full goes to the shadow; a third event is lost
      wire cap_to_sh = cap_ev && (shadow_valid_flag_reg[gi] ? move : !ch_empty);
      wire cmp_load = !capture_mode && load_point && shadow_valid_flag_reg[gi];
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          channel_register_reg[gi] <= 16'h0000;
          channel_shadow_reg[gi] <= 16'h0000;
          shadow_valid_flag_reg[gi] <= 1'b0;
          channel_flag_reg[gi] <= 1'b0;
          match_reg[gi] <= 1'b0;
          cap_irq_reg[gi] <= 1'b0;
        end else begin
          if (ch_wr) begin
            channel_register_reg[gi] <= reg_wdata[15:0];
          end else if (move || cmp_load) begin
            channel_register_reg[gi] <= (move ? move_val : channel_shadow_reg[gi]);
          end
          if (sh_wr) begin
            channel_shadow_reg[gi] <= reg_wdata[15:0];
          end else if (cap_to_sh && !(move && shadow_valid_flag_reg[gi] && !cap_ev)) begin
            channel_shadow_reg[gi] <= stamp;
          end
          if (capture_mode) begin
            shadow_valid_flag_reg[gi] <= cap_to_sh
                                       || (shadow_valid_flag_reg[gi] && !move);
          end else if (sh_wr) begin
            shadow_valid_flag_reg[gi] <= 1'b1;
          end else if (load_point) begin
            shadow_valid_flag_reg[gi] <= 1'b0;
          end
          // Set beats read-clear so a moved capture or a match is never hidden
          if (move) begin
            channel_flag_reg[gi] <= 1'b1;
          end else if (!capture_mode && count_tick && count_value_reg == channel_register_reg[gi]) begin
            channel_flag_reg[gi] <= 1'b1;
          end else if (ch_rd || ch_wr) begin
            channel_flag_reg[gi] <= 1'b0;
          end
          match_reg[gi] <= !capture_mode && count_tick
                        && (count_value_reg == channel_register_reg[gi]);
          cap_irq_reg[gi] <= move;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  wire [31:0] status_word = {16'h0000, 3'b000, period_valid_reg,
                             4'(shadow_valid_flag_reg), 4'(channel_flag_reg), 4'h0};
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (reg_addr == TBC_ADDR_CTRL) begin
      rd_mux = ctrl_reg;
    end else if (reg_addr == TBC_ADDR_STATUS) begin
      rd_mux = status_word;
    end else if (reg_addr == TBC_ADDR_COUNT) begin
      rd_mux = {16'h0000, count_value_reg};
    end else if (reg_addr == TBC_ADDR_PERIOD) begin
      rd_mux = {16'h0000, period_reg};
    end else if (reg_addr == TBC_ADDR_PER_SHADOW) begin
      rd_mux = {16'h0000, period_shadow_reg};
    end else if ((reg_addr[4:2] == TBC_ADDR_CH_BASE[4:2]) && (int'(ch_idx) < NUM_CH)) begin
      rd_mux = {16'h0000, channel_register_reg[ch_idx]};
    end else if ((reg_addr[4:2] == TBC_ADDR_SH_BASE[4:2]) && (int'(ch_idx) < NUM_CH)) begin
      rd_mux = {16'h0000, channel_shadow_reg[ch_idx]};
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_reg;
  assign overflow_event = ovf_reg;
  assign match_event = match_reg;
  assign channel_flag = channel_flag_reg;
  assign capture_irq = cap_irq_reg;
endmodule

/* File: tbc_timer_assertions.sv */
// Port checker for the timer base counter
`timescale 1ns/10ps
module tbc_timer_checker
  import tbc_pkg::*;
#(
  parameter int NUM_CH = 4,
  parameter int NUM_EV = 8,
  parameter int NUM_PRE = 7
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [NUM_PRE-1:0] prescale_tick,
  input wire logic [NUM_EV-1:0] event_in,
  input wire logic [NUM_EV-1:0] event_edge_rise,
  input wire logic quad_dir,
  input wire logic overflow_event,
  input wire logic [NUM_CH-1:0] match_event,
  input wire logic [NUM_CH-1:0] channel_flag,
  input wire logic [NUM_CH-1:0] capture_irq
);
  // ----------------------------------------
  // Shadow of control, from bus writes
  // ----------------------------------------
  logic [31:0] ctrl_reg;
  wire any_tick = (|prescale_tick) || (|event_in);
  wire [3:0] clk_sel = ctrl_reg[TBC_CTRL_CLKSRC_LSB +: 4];
  wire [2:0] ev_act = ctrl_reg[TBC_CTRL_EVENT_ACTION_SELECT_LSB +: 3];
  wire [NUM_CH-1:0] ch_en = ctrl_reg[TBC_CTRL_CHEN_LSB +: NUM_CH];
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= TBC_CTRL_RESET;
    end else if (reg_wr && reg_addr == TBC_ADDR_CTRL) begin
      ctrl_reg <= reg_wdata;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside its slot");
  a_ovf_after_tick: assert property (overflow_event |-> $past(any_tick))
    else $error("overflow without a count tick");
  a_match_after_tick: assert property (|match_event |-> $past(any_tick))
    else $error("match without a count tick");
  a_off_quiet: assert property (clk_sel == TBC_CLK_OFF |=> !overflow_event && match_event == '0)
    else $error("activity with clock source off");
  a_irq_has_flag: assert property ((capture_irq & ~channel_flag) == '0)
    else $error("capture irq without channel flag");
  a_flag_fall_access: assert property (($past(channel_flag) & ~channel_flag) != '0 |-> $past(reg_rd || reg_wr))
    else $error("channel flag cleared without access");
  a_irq_enabled_only: assert property ((capture_irq & ~$past(ch_en)) == '0)
    else $error("capture irq on disabled channel");
  a_match_not_capture: assert property (|match_event |-> $past(ev_act) != TBC_EV_CAPTURE)
    else $error("match pulse in capture mode");
  c_overflow: cover property (overflow_event);
  c_capture: cover property (|capture_irq);
  c_match: cover property (|match_event);
endmodule

bind tbc_timer tbc_timer_checker #(.NUM_CH(NUM_CH), .NUM_EV(NUM_EV), .NUM_PRE(NUM_PRE))
  tbc_timer_checker_i (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .prescale_tick(prescale_tick), .event_in(event_in), .event_edge_rise(event_edge_rise),
  .quad_dir(quad_dir), .overflow_event(overflow_event), .match_event(match_event),
  .channel_flag(channel_flag), .capture_irq(capture_irq));

/* File: tbc_timer_bench.sv */
// Self-checking bench for the timer base counter
`timescale 1ns/10ps
module tbc_timer_bench import tbc_pkg::*;;
  logic sys_clk, arst_n, reg_wr, reg_rd, overflow_event, quad_dir;
  logic [4:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [7:0] ev_req, ev_rise, event_in, event_edge_rise;
  logic [6:0] prescale_tick;
  logic [3:0] match_event, channel_flag, capture_irq;
  int n_mismatch = 0, cmp_count = 0, cycles = 0, ovf_n = 0, match_n = 0, irq0_n = 0, irq1_n = 0;
  tbc_evsys_model tbc_evsys_model_i (.sys_clk(sys_clk), .arst_n(arst_n), .ev_req(ev_req),
    .ev_rise(ev_rise), .cascade_in(overflow_event), .prescale_tick(prescale_tick),
    .event_in(event_in), .event_edge_rise(event_edge_rise));
  tbc_timer tbc_timer_i (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .prescale_tick(prescale_tick), .event_in(event_in), .event_edge_rise(event_edge_rise),
    .quad_dir(quad_dir), .overflow_event(overflow_event), .match_event(match_event),
    .channel_flag(channel_flag), .capture_irq(capture_irq));
  // ----------------------------------------
  // Clock, pulse counters and hang guard
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // Sampled mid-cycle so registered pulses are settled
  always @(negedge sys_clk) begin
    cycles++;
    ovf_n += int'(overflow_event === 1'b1);
    match_n += int'(match_event[0] === 1'b1);
    irq0_n += int'(capture_irq[0] === 1'b1);
    irq1_n += int'(capture_irq[1] === 1'b1);
    if (cycles == 3000) begin
      n_mismatch++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata & m, e);
  endtask
  task automatic ev(input logic [7:0] m, input logic [7:0] r);
    @(posedge sys_clk);
    ev_req <= m;
    ev_rise <= r;
    @(posedge sys_clk);
    ev_req <= 8'h00;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    repeat (8) @(posedge sys_clk);
    rd(TBC_ADDR_CTRL, 32'h0000_0000);
    rd(TBC_ADDR_PERIOD, 32'h0000_FFFF);
    rd(TBC_ADDR_COUNT, 32'h0000_0000);
  endtask
  task automatic t_up();
    wr(TBC_ADDR_CTRL, 32'h0000_0008);
    wr(TBC_ADDR_PERIOD, 32'h0000_0002);
    rd(TBC_ADDR_PERIOD, 32'h0000_0002);
    ev(8'h01, 8'h00);
    ev(8'h01, 8'h00);
    rd(TBC_ADDR_COUNT, 32'h0000_0002);
    ev(8'h01, 8'h00);
    rd(TBC_ADDR_COUNT, 32'h0000_0000);
    chk(ovf_n, 1);
  endtask
  task automatic t_down();
    wr(TBC_ADDR_CTRL, 32'h0000_0408);
    ev(8'h01, 8'h00);
    rd(TBC_ADDR_COUNT, 32'h0000_0002);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= TBC_ADDR_COUNT;
    reg_wdata <= 32'h0000_0005;
    ev_req <= 8'h01;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    ev_req <= 8'h00;
    rd(TBC_ADDR_COUNT, 32'h0000_0005);
    chk(ovf_n, 2);
  endtask
  task automatic t_buffer();
    wr(TBC_ADDR_CTRL, 32'h0000_1008);
    wr(TBC_ADDR_COUNT, 32'h0000_0001);
    wr(TBC_ADDR_PER_SHADOW, 32'h0000_0005);
    rd(TBC_ADDR_PERIOD, 32'h0000_0002);
    rd(TBC_ADDR_STATUS, 32'h0000_1000, 32'h0000_1000);
    ev(8'h01, 8'h00);
    ev(8'h01, 8'h00);
    rd(TBC_ADDR_PERIOD, 32'h0000_0005);
    rd(TBC_ADDR_STATUS, 32'h0000_0000, 32'h0000_1000);
  endtask
  task automatic t_compare();
    int m;
    wr(TBC_ADDR_CTRL, 32'h0000_0008);
    wr(TBC_ADDR_CH_BASE, 32'h0000_0003);
    m = match_n;
    repeat (4) ev(8'h01, 8'h00);
    repeat (2) @(posedge sys_clk);
    chk(match_n - m, 1);
    for (int i = 0; i < 4; i++) begin
      rd(5'(TBC_ADDR_CH_BASE + i), (i == 0) ? 32'h0000_0003 : 32'h0000_0000);
    end
  endtask
  task automatic t_capture();
    wr(TBC_ADDR_CTRL, 32'h0003_0118);
    wr(TBC_ADDR_COUNT, 32'h0000_0001);
    ev(8'h08, 8'h08);
    rd(TBC_ADDR_STATUS, 32'h0000_0020, 32'h0000_0020);
    chk(channel_flag, 32'h0000_0002);
    rd(5'(TBC_ADDR_CH_BASE + 1), 32'h0000_8001);
    ev(8'h04, 8'h00);
    wr(TBC_ADDR_COUNT, 32'h0000_0003);
    ev(8'h04, 8'h00);
    rd(TBC_ADDR_STATUS, 32'h0000_0100, 32'h0000_0100);
    ev(8'h10, 8'h10);
    rd(5'(TBC_ADDR_CH_BASE + 2), 32'h0000_0000);
    rd(TBC_ADDR_CH_BASE, 32'h0000_0001);
    rd(TBC_ADDR_CH_BASE, 32'h0000_0003);
    rd(TBC_ADDR_STATUS, 32'h0000_0000, 32'h0000_0100);
    chk(irq0_n + irq1_n, 3);
  endtask
  task automatic t_updown();
    wr(TBC_ADDR_CTRL, 32'h0000_00A8);
    wr(TBC_ADDR_COUNT, 32'h0000_0004);
    ev(8'h03, 8'h00);
    rd(TBC_ADDR_COUNT, 32'h0000_0003);
    ev(8'h01, 8'h00);
    rd(TBC_ADDR_COUNT, 32'h0000_0004);
    rd(5'h1F, 32'h0000_0000);
  endtask
  task automatic t_quad_wave();
    wr(TBC_ADDR_CTRL, 32'h0000_0838);
    wr(TBC_ADDR_CH_BASE, 32'h0000_0002);
    wr(TBC_ADDR_COUNT, 32'h0000_0002);
    ev(8'h01, 8'h00);
    rd(TBC_ADDR_COUNT, 32'h0000_0000);
    quad_dir <= 1'b1;
    ev(8'h01, 8'h00);
    rd(TBC_ADDR_COUNT, 32'h0000_0002);
    wr(TBC_ADDR_SH_BASE, 32'h0000_0007);
    rd(TBC_ADDR_STATUS, 32'h0000_0100, 32'h0000_0100);
    wr(TBC_ADDR_COUNT, 32'h0000_0000);
    ev(8'h01, 8'h00);
    rd(TBC_ADDR_CH_BASE, 32'h0000_0007);
    rd(TBC_ADDR_STATUS, 32'h0000_0000, 32'h0000_0100);
    quad_dir <= 1'b0;
  endtask
  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    arst_n = 1'b0;
    {reg_wr, reg_rd, reg_addr, reg_wdata, ev_req, ev_rise, quad_dir} = '0;
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_reset();
    t_up();
    t_down();
    t_buffer();
    t_compare();
    t_capture();
    t_updown();
    t_quad_wave();
    finish_test();
  end
endmodule
